/* File: design/cfd_fault_diag.v */
// Fault detection, flags and pin control of a high-speed CAN transceiver
//
// Summary of operation
// - Four consecutive faulty dominant-recessive transmit cycles set the bus-failure flag.
// - Bus-failure flag appears on the fault output only in Normal mode.
// - Bus-failure flag clears at reset and on entering Normal mode.
// - In Normal or Listen-only, any of four local events sets local-failure.
// - Local-failure flag appears on the fault output in Listen-only mode.
// - Resolved local failures clear at reset, Normal entry, or receive dominant/transmit recessive.
// - Transmit input low past its time-out disables the transmitter until flag clears.
// - A transmit-to-receive pin short disables the transmitter until flag clears.
// - Bus dominant past its time-out sets local-failure, transmitter stays enabled.
// - Bus clamping is not latched and releases when the bus goes recessive.
// - Overtemperature disables the transmitter and sets local-failure until the flag clears.
// - Split output driven in Normal and Listen-only, floating in other modes.
// - Either edge on the wake input is a local wake-up event.
// - Wake bias follows the filtered wake level: pull-up high, pull-down low.
// - Fault output low shows a set flag, high a cleared one.
`timescale 1ns/1ns
`include "cfd_defs.vh"

module cfd_fault_diag #(
  parameter [15:0] TXD_DOM_TO_US = `CFD_TXD_DOM_TO_US,
  parameter [15:0] BUS_DOM_TO_US = `CFD_BUS_DOM_TO_US,
  parameter [15:0] WAKE_FILT_US = `CFD_WAKE_FILT_US
) (
  // Clock and reset
  input wire CORE_CLK_I,
  input wire RST_N_I,
  // Operating mode from the mode controller
  input wire [2:0] MODE_I,
  // Pins and analog sense inputs
  input wire TXD_I,
  input wire RXD_SENSE_I,
  input wire BUS_DOM_I,
  input wire BUS_SHORT_I,
  input wire OVERTEMP_I,
  input wire WAKE_I,
  // Pin and analog control outputs
  output wire RXD_O,
  output wire ERR_N_O,
  output wire TX_EN_O,
  output wire SPLIT_EN_O,
  output wire WAKE_PULLUP_O,
  output wire WAKE_EVENT_O,
  // Register port
  input wire [7:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output wire [31:0] RDATA_O,
  // Interrupt
  output wire IRQ_O
);

  localparam [6:0] TICK_CYC = `CFD_TICK_CYC;
  localparam [15:0] TXD_MIN_US = `CFD_TXD_DOM_MIN_US;
  // One-hot states of the transmit cycle tracker
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_DOM = 3'b010;
  localparam [2:0] ST_REC = 3'b100;
  // Saturating increment shared by all timers
  function [15:0] sat_inc;
    input [15:0] v;
    begin
      sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
    end
  endfunction
  reg [5:0] sync1_reg, sync2_reg;
  reg [6:0] div_reg;
  reg [15:0] txd_cnt_reg, bus_cnt_reg, wake_cnt_reg;
  reg [2:0] state_reg, fail_cnt_reg, mode_reg, rxd_hist_reg, irq_st_reg, irq_en_reg;
  reg tick_reg, cyc_short_reg, bus_fail_reg, txd_clamp_reg, pin_short_reg, ot_reg;
  reg rxd_reg, err_n_reg, tx_en_reg, split_reg, wake_lvl_reg, wake_evt_reg, irq_reg, local_prev_reg;
  reg [31:0] rdata_reg, rdata_next;
  wire txd_s = sync2_reg[0];
  wire rxd_sense_s = sync2_reg[1];
  wire bus_dom_s = sync2_reg[2];
  wire bus_short_s = sync2_reg[3];
  wire ot_s = sync2_reg[4];
  wire wake_s = sync2_reg[5];
  wire in_normal = (MODE_I == `CFD_MODE_NORMAL);
  wire in_listen = (MODE_I == `CFD_MODE_LISTEN);
  wire diag_mode = in_normal | in_listen;
  wire enter_normal = in_normal & (mode_reg != `CFD_MODE_NORMAL);
  wire txd_timeout = (txd_cnt_reg >= TXD_DOM_TO_US);
  wire bus_clamp = (bus_cnt_reg >= BUS_DOM_TO_US);
  wire txd_long = (txd_cnt_reg >= TXD_MIN_US);
  wire short_now = (rxd_hist_reg == 3'h7) & ~rxd_sense_s;
  wire latched_fail = txd_clamp_reg | pin_short_reg | ot_reg;
  wire local_fail = latched_fail | bus_clamp;
  wire resolved = txd_s & ~short_now & ~ot_s & ~bus_clamp;
  wire clr_local = resolved & (enter_normal | (bus_dom_s & txd_s));
  wire set_txd_clamp = diag_mode & txd_timeout;
  wire set_short = diag_mode & short_now;
  wire set_ot = diag_mode & ot_s;
  wire bus_fail_set = (state_reg == ST_DOM) & txd_s & cyc_short_reg & in_normal &
    (fail_cnt_reg == `CFD_BUS_FAIL_CYCLES - 3'h1);
  wire wake_evt = (wake_s != wake_lvl_reg) & (wake_cnt_reg >= WAKE_FILT_US);
  wire local_rise = local_fail & ~local_prev_reg;
  wire wr_clr = WR_I & (ADDR_I == `CFD_REG_IRQ_CLEAR);
  // Two-stage synchronisers, reset to each line's idle level so no false cause follows reset
  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      sync1_reg <= 6'h23;
      sync2_reg <= 6'h23;
    end
    else
    begin
      sync1_reg <= {WAKE_I, OVERTEMP_I, BUS_SHORT_I, BUS_DOM_I, RXD_SENSE_I, TXD_I};
      sync2_reg <= sync1_reg;
    end
  end

  // Microsecond timebase and the time-out counters
  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      div_reg <= 7'h00;
      tick_reg <= 1'b0;
      txd_cnt_reg <= 16'h0000;
      bus_cnt_reg <= 16'h0000;
      wake_cnt_reg <= 16'h0000;
    end
    else
    begin
      tick_reg <= (div_reg == TICK_CYC - 7'h01);
      div_reg <= (div_reg == TICK_CYC - 7'h01) ? 7'h00 : div_reg + 7'h01;
      // Transmit low time
      if (txd_s)
        txd_cnt_reg <= 16'h0000;
      else if (tick_reg)
        txd_cnt_reg <= sat_inc(txd_cnt_reg);
      // Bus dominant time
      if (!bus_dom_s)
        bus_cnt_reg <= 16'h0000;
      else if (tick_reg)
        bus_cnt_reg <= sat_inc(bus_cnt_reg);
      // Wake level stability time
      if (wake_s == wake_lvl_reg || wake_evt)
        wake_cnt_reg <= 16'h0000;
      else if (tick_reg)
        wake_cnt_reg <= sat_inc(wake_cnt_reg);
    end
  end
  // Tracks transmit dominant-recessive cycles and counts faulty ones
  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_reg <= ST_IDLE;
      cyc_short_reg <= 1'b0;
      fail_cnt_reg <= 3'h0;
      bus_fail_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          cyc_short_reg <= 1'b0;
          if (in_normal && !txd_s)
            state_reg <= ST_DOM;
        end
        ST_DOM:
        begin
          // Short only counts once our driver has held dominant long enough
          if (!txd_s && txd_long && bus_short_s && tx_en_reg)
            cyc_short_reg <= 1'b1;
          if (!in_normal)
            state_reg <= ST_IDLE;
          else if (txd_s)
          begin
            state_reg <= ST_REC;
            if (cyc_short_reg)
              fail_cnt_reg <= (fail_cnt_reg == `CFD_BUS_FAIL_CYCLES) ?
                fail_cnt_reg : fail_cnt_reg + 3'h1;
            else
              fail_cnt_reg <= 3'h0;
          end
        end
        ST_REC:
        begin
          cyc_short_reg <= 1'b0;
          if (!in_normal)
            state_reg <= ST_IDLE;
          else if (!txd_s)
            state_reg <= ST_DOM;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
      if (enter_normal)
        fail_cnt_reg <= 3'h0;
      // Set wins; entry into Normal otherwise clears
      if (bus_fail_set)
        bus_fail_reg <= 1'b1;
      else if (enter_normal)
        bus_fail_reg <= 1'b0;
    end
  end

  // Latched local failure causes
  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      txd_clamp_reg <= 1'b0;
      pin_short_reg <= 1'b0;
      ot_reg <= 1'b0;
      mode_reg <= `CFD_MODE_STANDBY;
      rxd_hist_reg <= 3'h0;
    end
    else
    begin
      mode_reg <= MODE_I;
      rxd_hist_reg <= {rxd_hist_reg[1:0], rxd_reg};
      if (set_txd_clamp)
        txd_clamp_reg <= 1'b1;
      else if (clr_local)
        txd_clamp_reg <= 1'b0;
      if (set_short)
        pin_short_reg <= 1'b1;
      else if (clr_local)
        pin_short_reg <= 1'b0;
      if (set_ot)
        ot_reg <= 1'b1;
      else if (clr_local)
        ot_reg <= 1'b0;
    end
  end

  // Pin outputs: receive data, fault indicator, transmitter and split
  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rxd_reg <= 1'b1;
      err_n_reg <= 1'b1;
      tx_en_reg <= 1'b0;
      split_reg <= 1'b0;
    end
    else
    begin
      rxd_reg <= ~bus_dom_s;
      if (in_normal)
        err_n_reg <= ~bus_fail_reg;
      else if (in_listen)
        err_n_reg <= ~local_fail;
      else
        err_n_reg <= 1'b1;
      // Bus clamp alone leaves the driver on
      tx_en_reg <= in_normal & ~latched_fail & ~set_txd_clamp & ~set_short & ~set_ot;
      split_reg <= diag_mode;
    end
  end

  // Wake filter, bias control and wake event
  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      wake_lvl_reg <= 1'b1;
      wake_evt_reg <= 1'b0;
    end
    else
    begin
      wake_evt_reg <= wake_evt;
      if (wake_evt)
        wake_lvl_reg <= wake_s;
    end
  end

  // Interrupt status, enable and level output
  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      irq_st_reg <= 3'h0;
      irq_en_reg <= `CFD_IRQ_EN_RST;
      local_prev_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      local_prev_reg <= local_fail;
      if (WR_I && ADDR_I == `CFD_REG_IRQ_ENABLE)
        irq_en_reg <= WDATA_I[`CFD_IRQ_W-1:0];
      // Set beats a clear in the same cycle
      irq_st_reg <= (irq_st_reg & ~(wr_clr ? WDATA_I[`CFD_IRQ_W-1:0] : 3'h0)) |
        {wake_evt, local_rise, bus_fail_set};
      irq_reg <= |(irq_st_reg & irq_en_reg);
    end
  end

  // Read decode; unmapped and write-only offsets read zero
  always @*
  begin
    rdata_next = 32'h0000_0000;
    if (ADDR_I == `CFD_REG_STATUS)
    begin
      rdata_next[`CFD_ST_BUS_FAIL] = bus_fail_reg;
      rdata_next[`CFD_ST_LOCAL_FAIL] = local_fail;
      rdata_next[`CFD_ST_TXD_CLAMP] = txd_clamp_reg;
      rdata_next[`CFD_ST_PIN_SHORT] = pin_short_reg;
      rdata_next[`CFD_ST_BUS_CLAMP] = bus_clamp;
      rdata_next[`CFD_ST_OVERTEMP] = ot_reg;
      rdata_next[`CFD_ST_TX_OFF] = ~tx_en_reg;
      rdata_next[`CFD_ST_WAKE_LEVEL] = wake_lvl_reg;
    end
    else if (ADDR_I == `CFD_REG_IRQ_STATUS)
      rdata_next[`CFD_IRQ_W-1:0] = irq_st_reg;
    else if (ADDR_I == `CFD_REG_IRQ_ENABLE)
      rdata_next[`CFD_IRQ_W-1:0] = irq_en_reg;
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= RD_I ? rdata_next : 32'h0000_0000;
  end
  assign RXD_O = rxd_reg;
  assign ERR_N_O = err_n_reg;
  assign TX_EN_O = tx_en_reg;
  assign SPLIT_EN_O = split_reg;
  assign WAKE_PULLUP_O = wake_lvl_reg;
  assign WAKE_EVENT_O = wake_evt_reg;
  assign RDATA_O = rdata_reg;
  assign IRQ_O = irq_reg;
endmodule // cfd_fault_diag

/* File: design/cfd_defs.vh */
// Constants for the CAN transceiver fault diagnostics block
`ifndef CFD_DEFS_VH
`define CFD_DEFS_VH
// Clock and local timebase
`define CFD_CLK_MHZ 100
`define CFD_TICK_US 1
`define CFD_TICK_CYC 7'h64
// Default time-outs in microseconds
`define CFD_TXD_DOM_TO_US 16'h03E8
`define CFD_BUS_DOM_TO_US 16'h03E8
`define CFD_WAKE_FILT_US 16'h0032
`define CFD_TXD_DOM_MIN_US 16'h0004
// Bus failure needs this many consecutive faulty cycles
`define CFD_BUS_FAIL_CYCLES 3'h4
// Operating mode codes
`define CFD_MODE_NORMAL 3'h0
`define CFD_MODE_LISTEN 3'h1
`define CFD_MODE_STANDBY 3'h2
`define CFD_MODE_GOSLEEP 3'h3
`define CFD_MODE_SLEEP 3'h4
// Register byte offsets
`define CFD_REG_STATUS 8'h00
`define CFD_REG_IRQ_STATUS 8'h04
`define CFD_REG_IRQ_CLEAR 8'h08
`define CFD_REG_IRQ_ENABLE 8'h0C
// Status field positions
`define CFD_ST_BUS_FAIL 0
`define CFD_ST_LOCAL_FAIL 1
`define CFD_ST_TXD_CLAMP 2
`define CFD_ST_PIN_SHORT 3
`define CFD_ST_BUS_CLAMP 4
`define CFD_ST_OVERTEMP 5
`define CFD_ST_TX_OFF 6
`define CFD_ST_WAKE_LEVEL 7
// Interrupt field positions
`define CFD_IRQ_BUS_FAIL 0
`define CFD_IRQ_LOCAL_FAIL 1
`define CFD_IRQ_WAKE 2
`define CFD_IRQ_W 3
// Reset values
`define CFD_IRQ_EN_RST 3'h0
`endif

/* File: tb/cfd_fault_diag_chk.sv */
// Port assertions for the fault diagnostics block
`timescale 1ns/1ns
module cfd_fault_diag_chk (
  // Clock and reset
  input wire CORE_CLK_I,
  input wire RST_N_I,
  // Watched inputs
  input wire [2:0] MODE_I,
  input wire OVERTEMP_I,
  input wire WAKE_I,
  input wire RD_I,
  input wire RXD_SENSE_I,
  // Watched outputs
  input wire RXD_O,
  input wire ERR_N_O,
  input wire TX_EN_O,
  input wire SPLIT_EN_O,
  input wire WAKE_PULLUP_O,
  input wire WAKE_EVENT_O,
  input wire [31:0] RDATA_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Split drive tracks the mode one cycle later
  property p_split;
    $stable(MODE_I) |=> SPLIT_EN_O == ($past(MODE_I) < 3'h2);
  endproperty
  a_split: assert property (p_split) else $error("split drive wrong");
  // Low-power modes never show a flag
  property p_idle;
    MODE_I >= 3'h2 [*2] |=> ERR_N_O;
  endproperty
  a_idle: assert property (p_idle) else $error("fault shown in low-power mode");
  // Wake event is a single-cycle pulse
  property p_wake_pulse;
    WAKE_EVENT_O |=> !WAKE_EVENT_O;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
  // Bias only moves towards the settled pin level
  property p_wake_bias;
    $changed(WAKE_PULLUP_O) |-> WAKE_PULLUP_O == $past(WAKE_I, 4);
  endproperty
  a_wake_bias: assert property (p_wake_bias) else $error("wake bias wrong");
  // Overtemperature keeps the driver off
  property p_ot;
    (OVERTEMP_I && MODE_I < 3'h2) [*6] |-> !TX_EN_O;
  endproperty
  a_ot: assert property (p_ot) else $error("driver on while hot");
  // Listen-only shows the local failure
  property p_listen;
    (OVERTEMP_I && MODE_I == 3'h1) [*6] |=> !ERR_N_O;
  endproperty
  a_listen: assert property (p_listen) else $error("local failure not shown");
  // A receive pin pulled low while idle kills the driver
  property p_short;
    (MODE_I < 3'h2 && RXD_O && !RXD_SENSE_I) [*8] |-> !TX_EN_O;
  endproperty
  a_short: assert property (p_short) else $error("pin short missed");
  // Entering Normal drops the bus failure
  property p_enter;
    MODE_I != 3'h0 ##1 MODE_I == 3'h0 [*2] |=> ERR_N_O;
  endproperty
  a_enter: assert property (p_enter) else $error("bus failure kept on entry");
  // Read data only in the cycle after a read
  property p_rdata;
    !RD_I |=> RDATA_O == 32'h0000_0000;
  endproperty
  a_rdata: assert property (p_rdata) else $error("stray read data");
  c_ot: cover property (OVERTEMP_I && !TX_EN_O);
  c_wake: cover property (WAKE_EVENT_O);
  c_err: cover property (MODE_I == 3'h0 && !ERR_N_O);
endmodule // cfd_fault_diag_chk

bind cfd_fault_diag cfd_fault_diag_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
  .MODE_I(MODE_I), .OVERTEMP_I(OVERTEMP_I), .WAKE_I(WAKE_I), .RD_I(RD_I),
  .RXD_SENSE_I(RXD_SENSE_I), .RXD_O(RXD_O), .ERR_N_O(ERR_N_O), .TX_EN_O(TX_EN_O),
  .SPLIT_EN_O(SPLIT_EN_O), .WAKE_PULLUP_O(WAKE_PULLUP_O), .WAKE_EVENT_O(WAKE_EVENT_O),
  .RDATA_O(RDATA_O));

/* File: tb/cfd_host_model.sv */
// Host protocol controller model: drives transmit, reads receive
`timescale 1ns/1ns
module cfd_host_model (
  // Clock
  input wire clk_i,
  // Pins
  input wire rxd_i,
  input wire short_i,
  output logic txd_o,
  output wire rxd_sense_o
);
  // A shorted transmit pin drags the receive pin low
  assign rxd_sense_o = short_i ? 1'b0 : rxd_i;
  initial txd_o = 1'b1;
  // One dominant-recessive cycle, dominant length in microseconds
  task cycle(input int us);
    @(posedge clk_i);
    txd_o <= 1'b0;
    repeat (us * 100) @(posedge clk_i);
    txd_o <= 1'b1;
    repeat (300) @(posedge clk_i);
  endtask
endmodule // cfd_host_model

/* File: tb/tb_can_transceiver_fault_diagnostics.sv */
// Self-checking bench for the fault diagnostics block
`timescale 1ns/1ns
`include "cfd_defs.vh"
module tb_can_transceiver_fault_diagnostics;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] mode = `CFD_MODE_STANDBY;
  logic bus_short = 1'b0;
  logic clamp = 1'b0;
  logic ot = 1'b0;
  logic wake = 1'b1;
  logic short = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  wire txd, rxd, sense, err_n, tx_en, split, pull, irq, wake_evt;
  int wake_pulses = 0;
  wire [31:0] rdata;
  wire [2:0] obs = {pull, err_n, tx_en};
  int mismatches = 0;
  int cmp_count = 0;
  // Bus is dominant when clamped or driven by the enabled transmitter
  wire bus_dom = clamp | (~txd & tx_en);
  always #5 clk = ~clk;
  // Counts accepted wake events on the one-cycle pulse output
  always @(posedge clk)
    if (wake_evt === 1'b1)
      wake_pulses <= wake_pulses + 1;
  cfd_host_model host (.clk_i(clk), .rxd_i(rxd), .short_i(short), .txd_o(txd),
    .rxd_sense_o(sense));
  cfd_fault_diag #(.TXD_DOM_TO_US(16'd8), .BUS_DOM_TO_US(16'd20), .WAKE_FILT_US(16'd2)) dut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .MODE_I(mode), .TXD_I(txd), .RXD_SENSE_I(sense),
    .BUS_DOM_I(bus_dom), .BUS_SHORT_I(bus_short), .OVERTEMP_I(ot), .WAKE_I(wake),
    .RXD_O(rxd), .ERR_N_O(err_n), .TX_EN_O(tx_en), .SPLIT_EN_O(split),
    .WAKE_PULLUP_O(pull), .WAKE_EVENT_O(wake_evt), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq));
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Ends on a falling edge so outputs are settled
  task step(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(n, rdata & m, e);
  endtask
  // Bounded wait for one of pull-up, fault and driver enable
  task wt(input string n, input int s, input logic v);
    int k;
    k = 0;
    @(negedge clk);
    while (obs[s] !== v && k < 6000)
    begin
      @(negedge clk);
      k++;
    end
    chk(n, obs[s], v);
    if (k == 6000)
    begin
      mismatches++;
      end_of_test;
    end
  endtask
  // Short dominant bus with transmit recessive
  task pulse_dom;
    @(posedge clk) clamp <= 1'b1;
    step(10);
    @(posedge clk) clamp <= 1'b0;
  endtask
  initial
  begin
    step(8);
    @(posedge clk) rst_n <= 1'b1;
    step(4);
    chk("err_n", err_n, 1'b1);
    chk("pull", pull, 1'b1);
    rd_reg("irq_en", `CFD_REG_IRQ_ENABLE, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_reg("unmapped", 8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    for (int m = 0; m < 5; m++)
    begin
      @(posedge clk) mode <= m[2:0];
      step(3);
      chk("split", split, m < 2);
    end
    // Four faulty transmit cycles raise the bus failure
    wr_reg(`CFD_REG_IRQ_ENABLE, 32'h0000_0001);
    @(posedge clk) mode <= `CFD_MODE_NORMAL;
    bus_short <= 1'b1;
    repeat (3) host.cycle(6);
    step(1);
    chk("err_n", err_n, 1'b1);
    host.cycle(6);
    wt("err_n", 1, 1'b0);
    chk("irq", irq, 1'b1);
    rd_reg("irq_st", `CFD_REG_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
    wr_reg(`CFD_REG_IRQ_CLEAR, 32'h0000_0001);
    bus_short <= 1'b0;
    step(2);
    chk("irq", irq, 1'b0);
    rd_reg("clr", `CFD_REG_IRQ_CLEAR, 32'hFFFF_FFFF, 32'h0000_0000);
    @(posedge clk) mode <= `CFD_MODE_LISTEN;
    step(4);
    chk("err_n", err_n, 1'b1);
    @(posedge clk) mode <= `CFD_MODE_NORMAL;
    step(4);
    rd_reg("status", `CFD_REG_STATUS, 32'h0000_0003, 32'h0000_0000);
    chk("tx_en", tx_en, 1'b1);
    // Transmit clamped dominant
    host.cycle(12);
    wt("tx_en", 0, 1'b0);
    rd_reg("status", `CFD_REG_STATUS, 32'h0000_0046, 32'h0000_0046);
    pulse_dom;
    wt("tx_en", 0, 1'b1);
    // Transmit shorted to receive
    @(posedge clk) short <= 1'b1;
    wt("tx_en", 0, 1'b0);
    @(posedge clk) short <= 1'b0;
    @(posedge clk) mode <= `CFD_MODE_LISTEN;
    step(4);
    @(posedge clk) mode <= `CFD_MODE_NORMAL;
    wt("tx_en", 0, 1'b1);
    // Overtemperature seen in Listen-only, latched into Normal
    @(posedge clk) mode <= `CFD_MODE_LISTEN;
    @(posedge clk) ot <= 1'b1;
    wt("err_n", 1, 1'b0);
    @(posedge clk) mode <= `CFD_MODE_NORMAL;
    step(5);
    chk("tx_en", tx_en, 1'b0);
    @(posedge clk) ot <= 1'b0;
    step(10);
    chk("tx_en", tx_en, 1'b0);
    pulse_dom;
    wt("tx_en", 0, 1'b1);
    // Bus clamped dominant: flagged live, driver kept on
    @(posedge clk) clamp <= 1'b1;
    step(2500);
    chk("tx_en", tx_en, 1'b1);
    rd_reg("status", `CFD_REG_STATUS, 32'h0000_0012, 32'h0000_0012);
    @(posedge clk) clamp <= 1'b0;
    step(10);
    rd_reg("status", `CFD_REG_STATUS, 32'h0000_0012, 32'h0000_0000);
    // Wake on both edges, interrupt raised, cleared and masked
    wr_reg(`CFD_REG_IRQ_ENABLE, 32'h0000_0004);
    @(posedge clk) wake <= 1'b0;
    wt("pull", 2, 1'b0);
    step(2);
    chk("irq", irq, 1'b1);
    chk("wake_evt", wake_pulses, 32'h0000_0001);
    wr_reg(`CFD_REG_IRQ_CLEAR, 32'h0000_0004);
    step(2);
    chk("irq", irq, 1'b0);
    @(posedge clk) wake <= 1'b1;
    wt("pull", 2, 1'b1);
    step(2);
    chk("irq", irq, 1'b1);
    chk("wake_evt", wake_pulses, 32'h0000_0002);
    wr_reg(`CFD_REG_IRQ_ENABLE, 32'h0000_0000);
    step(2);
    chk("irq", irq, 1'b0);
    end_of_test;
  end
endmodule // tb_can_transceiver_fault_diagnostics
